// [testbench/tb_usb_endpoint_fifo_alloc.sv]
// self-checking bench for the endpoint fifo allocation block
`timescale 1ns/1ps
`default_nettype none
module tb_usb_endpoint_fifo_alloc;
   logic [9:0]  awa, ara;
   logic [31:0] wd, rd_d;
   logic        clk, rst, awv, awr, wv, wr_r, bv, brdy, arv, arr, rv, rrdy;
   logic [1:0]  br, rr, f_ep;
   logic        f_in, f_ok, opr, irq, h_byte, h_done, h_go, h_slow, h_busy, fgo, pgo, fd;
   logic [15:0] f_a;
   logic [6:0]  cnt, h_n;
   int          n_fail, cmp_count, seed;
   logic [1:0]  wq[$];
   logic [33:0] rq[$];
   logic        fq[$];
   logic [8:0]  pq[$];
   logic [15:0] bases[4], sizes[4];

   uefa_top dut_u (
      .clk               (clk),
      .rst               (rst),
      .s_axi_awaddr      (awa),
      .s_axi_awvalid     (awv),
      .s_axi_awready     (awr),
      .s_axi_wdata       (wd),
      .s_axi_wstrb       (4'hF),
      .s_axi_wvalid      (wv),
      .s_axi_wready      (wr_r),
      .s_axi_bresp       (br),
      .s_axi_bvalid      (bv),
      .s_axi_bready      (brdy),
      .s_axi_araddr      (ara),
      .s_axi_arvalid     (arv),
      .s_axi_arready     (arr),
      .s_axi_rdata       (rd_d),
      .s_axi_rresp       (rr),
      .s_axi_rvalid      (rv),
      .s_axi_rready      (rrdy),
      .ep0_rx_byte       (h_byte),
      .ep0_rx_done       (h_done),
      .fifo_ep           (f_ep),
      .fifo_dir_in       (f_in),
      .fifo_addr         (f_a),
      .fifo_access_ok    (f_ok),
      .ep0_rx_byte_count (cnt),
      .out_packet_ready  (opr),
      .irq               (irq)
   );

   uefa_host_model host_u (
      .clk         (clk),
      .start       (h_go),
      .n_bytes     (h_n),
      .slow        (h_slow),
      .busy        (h_busy),
      .ep0_rx_byte (h_byte),
      .ep0_rx_done (h_done)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string s);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected at %0t: %s got %h exp %h", $time, s, g, e);
      end
   endtask : cmp

   task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] e);
      wq.push_back(e);
      @(posedge clk);
      awa <= {i, 2'h0};
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      do begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr_r) wv <= 1'b0;
      end while (!(bv && brdy));
      brdy <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] i, input logic [31:0] d, input logic [1:0] e);
      rq.push_back({e, d});
      @(posedge clk);
      ara <= {i, 2'h0};
      arv <= 1'b1;
      rrdy <= 1'b1;
      do begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
      end while (!(rv && rrdy));
      rrdy <= 1'b0;
   endtask : rd

   task automatic fq_do(input int ep, input logic din, input logic [15:0] a, input logic e);
      fq.push_back(e);
      @(posedge clk);
      f_ep <= ep[1:0];
      f_in <= din;
      f_a <= a;
      fgo <= 1'b1;
      @(posedge clk);
      fgo <= 1'b0;
   endtask : fq_do

   task automatic pchk(input logic o, input logic [6:0] c, input logic q);
      pq.push_back({o, c, q});
      @(posedge clk);
      pgo <= 1'b1;
      @(posedge clk);
      pgo <= 1'b0;
   endtask : pchk

   task automatic pkt(input logic [6:0] n, input logic s);
      @(posedge clk);
      h_n <= n;
      h_slow <= s;
      h_go <= 1'b1;
      @(posedge clk);
      h_go <= 1'b0;
      do @(posedge clk); while (h_busy);
      repeat (2) @(posedge clk);
   endtask : pkt

   // m: 0 split, 1 single in, 2 single out
   function automatic logic exp_ok(int ep, logic din, logic [15:0] a, int m, logic en);
      logic [15:0] lo, hi;
      lo = bases[ep];
      hi = bases[ep] + sizes[ep];
      if (ep != 0 && m == 0) begin
         if (din) lo = lo + (sizes[ep] >> 1);
         else hi = lo + (sizes[ep] >> 1);
      end
      return (ep == 0 || (en && (m == 0 || din == (m == 1)))) && a >= lo && a < hi;
   endfunction : exp_ok

   function automatic logic [31:0] ctl(int m);
      return (32'(m == 0) << uefa_pkg::BIT_SPLIT) | (32'(m == 1) << uefa_pkg::BIT_ENDPOINT_DIRECTION_SELECT);
   endfunction : ctl

   task automatic cfg(input int ep, input int m);
      wr(uefa_pkg::IDX_INDEX, 32'(ep), uefa_pkg::RESP_OKAY);
      wr(uefa_pkg::IDX_IN_CTRL_HI, ctl(m), uefa_pkg::RESP_OKAY);
   endtask : cfg

   // probes both edges of each half plus two random points inside
   task automatic sweep(input int ep, input int m, input logic en);
      logic [15:0] b, s, h, pts[8];
      logic [31:0] r;
      b = bases[ep];
      s = sizes[ep];
      h = s >> 1;
      r = $random(seed);
      pts = '{b - 16'h1, b, b + h - 16'h1, b + h, b + s - 16'h1, b + s,
              b + r[15:0] % s, b + r[31:16] % h};
      for (int d = 0; d < 2; d++)
         for (int k = 0; k < 8; k++)
            fq_do(ep, d[0], pts[k], exp_ok(ep, d[0], pts[k], m, en));
   endtask : sweep

   always @(posedge clk) begin
      if (bv && brdy) cmp(32'(br), 32'(wq.pop_front()), "bresp");
      if (rv && rrdy) begin
         cmp(32'(rr), 32'(rq[0][33:32]), "rresp");
         if (rq[0][33:32] === uefa_pkg::RESP_OKAY) cmp(rd_d, rq[0][31:0], "rdata");
         void'(rq.pop_front());
      end
      if (fd === 1'b1) cmp(32'(f_ok), 32'(fq.pop_front()), "window");
      fd = fgo;
      if (pgo === 1'b1) cmp(32'({opr, cnt, irq}), 32'(pq.pop_front()), "ep0 status");
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      $display("unexpected at %0t: watchdog expired", $time);
      print_verdict();
   end

   initial begin
      logic [31:0] r;
      logic [6:0]  n;
      seed = 32'h0E49;
      n_fail = 0;
      cmp_count = 0;
      bases = '{uefa_pkg::EP0_BASE, uefa_pkg::EP1_BASE, uefa_pkg::EP2_BASE, uefa_pkg::EP3_BASE};
      sizes = '{uefa_pkg::EP0_SIZE, uefa_pkg::EP1_SIZE, uefa_pkg::EP2_SIZE, uefa_pkg::EP3_SIZE};
      {rst, awv, wv, brdy, arv, rrdy, fgo, pgo, h_go, h_slow, f_in} = 11'h400;
      {awa, ara, wd, f_ep, f_a, h_n} = '0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(uefa_pkg::IDX_EP0_CNT, 32'h0, uefa_pkg::RESP_OKAY);
      rd(uefa_pkg::IDX_ENABLE, 32'hF, uefa_pkg::RESP_OKAY);
      pchk(1'b0, 7'h00, 1'b0);
      wr(uefa_pkg::IDX_EP0_CNT, 32'hFF, uefa_pkg::RESP_OKAY);
      rd(uefa_pkg::IDX_EP0_CNT, 32'h0, uefa_pkg::RESP_OKAY);
      wr(8'h3F, 32'h1, uefa_pkg::RESP_SLVERR);
      rd(8'h3F, 32'h0, uefa_pkg::RESP_SLVERR);
      cfg(0, 0);
      rd(uefa_pkg::IDX_IN_CTRL_HI, 32'h0, uefa_pkg::RESP_OKAY);
      for (int ep = 1; ep < 4; ep++)
         for (int m = 0; m < 3; m++) begin
            cfg(ep, m);
            rd(uefa_pkg::IDX_IN_CTRL_HI, ctl(m), uefa_pkg::RESP_OKAY);
            sweep(ep, m, 1'b1);
         end
      for (int ep = 1; ep < 4; ep++) cfg(ep, ep - 1);
      for (int ep = 1; ep < 4; ep++) begin
         wr(uefa_pkg::IDX_INDEX, 32'(ep), uefa_pkg::RESP_OKAY);
         rd(uefa_pkg::IDX_IN_CTRL_HI, ctl(ep - 1), uefa_pkg::RESP_OKAY);
      end
      sweep(0, 0, 1'b1);
      wr(uefa_pkg::IDX_ENABLE, 32'h0, uefa_pkg::RESP_OKAY);
      rd(uefa_pkg::IDX_ENABLE, 32'h1, uefa_pkg::RESP_OKAY);
      sweep(2, 1, 1'b0);
      wr(uefa_pkg::IDX_ENABLE, 32'hE, uefa_pkg::RESP_OKAY);
      wr(uefa_pkg::IDX_IRQ_STAT, 32'h3, uefa_pkg::RESP_OKAY);
      wr(uefa_pkg::IDX_IRQ_MASK, 32'h1, uefa_pkg::RESP_OKAY);
      rd(uefa_pkg::IDX_IRQ_STAT, 32'h0, uefa_pkg::RESP_OKAY);
      r = $random(seed);
      n = 7'h01 + 7'(r % 32'h3F);
      pkt(n, 1'b0);
      pchk(1'b1, n, 1'b1);
      rd(uefa_pkg::IDX_EP0_CNT, 32'(n), uefa_pkg::RESP_OKAY);
      rd(uefa_pkg::IDX_EP0_CNT, 32'(n), uefa_pkg::RESP_OKAY);
      rd(uefa_pkg::IDX_EP0_CTRL, 32'h1, uefa_pkg::RESP_OKAY);
      rd(uefa_pkg::IDX_IRQ_STAT, 32'h1, uefa_pkg::RESP_OKAY);
      wr(uefa_pkg::IDX_IRQ_MASK, 32'h0, uefa_pkg::RESP_OKAY);
      pchk(1'b1, n, 1'b0);
      wr(uefa_pkg::IDX_IRQ_MASK, 32'h1, uefa_pkg::RESP_OKAY);
      wr(uefa_pkg::IDX_IRQ_STAT, 32'h1, uefa_pkg::RESP_OKAY);
      pchk(1'b1, n, 1'b0);
      wr(uefa_pkg::IDX_EP0_CTRL, 32'h1, uefa_pkg::RESP_OKAY);
      pchk(1'b0, 7'h00, 1'b0);
      // overlong packet: counter holds at the endpoint 0 size
      pkt(7'h46, 1'b1);
      pchk(1'b1, 7'h40, 1'b1);
      rd(uefa_pkg::IDX_EP0_CNT, 32'h40, uefa_pkg::RESP_OKAY);
      pkt(7'h05, 1'b0);
      pchk(1'b1, 7'h40, 1'b1);
      print_verdict();
   end
endmodule : tb_usb_endpoint_fifo_alloc
`default_nettype wire

// [testbench/uefa_host_model.sv]
// usb host stand-in that delivers endpoint 0 packets
`timescale 1ns/1ps
`default_nettype none
module uefa_host_model (
   input  wire logic       clk,
   input  wire logic       start,
   input  wire logic [6:0] n_bytes,
   input  wire logic       slow,
   output logic            busy,
   output logic            ep0_rx_byte,
   output logic            ep0_rx_done
);
   initial begin
      busy = 1'b0;
      ep0_rx_byte = 1'b0;
      ep0_rx_done = 1'b0;
      forever begin
         @(posedge clk);
         if (start) begin
            busy <= 1'b1;
            for (int i = 0; i < n_bytes; i++) begin
               ep0_rx_byte <= 1'b1;
               @(posedge clk);
               if (slow) begin
                  ep0_rx_byte <= 1'b0;
                  @(posedge clk);
               end
            end
            // completion only after the last data byte
            ep0_rx_byte <= 1'b0;
            ep0_rx_done <= 1'b1;
            @(posedge clk);
            ep0_rx_done <= 1'b0;
            busy <= 1'b0;
         end
      end
   end
endmodule : uefa_host_model
`default_nettype wire

// [verilog/uefa_alloc.sv]
// per-endpoint fifo window computation for endpoints 1 to 3
`timescale 1ns/1ps
`default_nettype none
module uefa_alloc (
   uefa_cfg_if.alloc cfg
);
   localparam logic [15:0] BASES [3] = '{uefa_pkg::EP1_BASE, uefa_pkg::EP2_BASE,
                                         uefa_pkg::EP3_BASE};
   localparam logic [15:0] SIZES [3] = '{uefa_pkg::EP1_SIZE, uefa_pkg::EP2_SIZE,
                                         uefa_pkg::EP3_SIZE};
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_ep
         logic [15:0] half;
         logic [15:0] top;
         assign half = SIZES[g] >> 1;
         assign top  = BASES[g] + SIZES[g] - 16'h0001;
         always_comb begin
            cfg.win[g] = '0;
            if (cfg.enable[g]) begin
               if (cfg.split[g]) begin
                  // upper half to the in pipe, lower half to the out pipe
                  cfg.win[g].in_ok  = 1'b1;
                  cfg.win[g].out_ok = 1'b1;
                  cfg.win[g].in_lo  = BASES[g] + half;
                  cfg.win[g].in_hi  = top;
                  cfg.win[g].out_lo = BASES[g];
                  cfg.win[g].out_hi = BASES[g] + half - 16'h0001;
               end else begin
                  // whole region merged, one direction only
                  cfg.win[g].in_ok  = cfg.dir_in[g];
                  cfg.win[g].out_ok = ~cfg.dir_in[g];
                  cfg.win[g].in_lo  = BASES[g];
                  cfg.win[g].in_hi  = top;
                  cfg.win[g].out_lo = BASES[g];
                  cfg.win[g].out_hi = top;
               end
            end
         end
      end
   endgenerate
endmodule : uefa_alloc
`default_nettype wire

// [verilog/uefa_cfg_if.sv]
// configuration and window bundle between the register file and the allocator
`timescale 1ns/1ps
`default_nettype none
interface uefa_cfg_if;
   logic [2:0]          split;
   logic [2:0]          dir_in;
   logic [2:0]          enable;
   uefa_pkg::uefa_win_s win [3];
   modport cfg (output split, output dir_in, output enable, input win);
   modport alloc (input split, input dir_in, input enable, output win);
endinterface : uefa_cfg_if
`default_nettype wire

// [verilog/uefa_ep0_count.sv]
// endpoint 0 received byte counter
`timescale 1ns/1ps
`default_nettype none
module uefa_ep0_count (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       rx_byte,
   input  wire logic       rx_done,
   input  wire logic       serviced,
   output logic [6:0]      count,
   output logic            out_packet_ready,
   output logic            pkt_event
);
   typedef struct packed {
      logic [6:0] count;
      logic       rdy;
      logic       ev;
   } uefa_c0_s;
   uefa_c0_s st;
   uefa_c0_s next_st;
   always_comb begin
      next_st    = st;
      next_st.ev = 1'b0;
      if (serviced) begin
         next_st.rdy   = 1'b0;
         next_st.count = uefa_pkg::CNT_RST;
      end
      // a new packet is only accepted after firmware serviced the last one
      if (!st.rdy && rx_byte && st.count != 7'h40) begin
         next_st.count = st.count + 7'h01;
      end
      if (!st.rdy && rx_done) begin
         next_st.rdy = 1'b1;
         next_st.ev  = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign count            = st.count;
   assign out_packet_ready = st.rdy;
   assign pkt_event        = st.ev;
   chk_count_frozen: assert property (@(posedge clk) disable iff (rst)
      (st.rdy && !serviced) |=> $stable(st.count))
      else $error("ep0 count moved while out packet ready");
   chk_ready_clear: assert property (@(posedge clk) disable iff (rst)
      (serviced && !rx_done) |=> !st.rdy && st.count == 7'h00)
      else $error("service did not clear ep0 state");
endmodule : uefa_ep0_count
`default_nettype wire

// [verilog/uefa_pkg.sv]
// constants and types for the usb endpoint fifo allocation block
`default_nettype none
package uefa_pkg;
   // fifo storage
   localparam int unsigned FIFO_BYTES     = 1024;
   localparam logic [15:0] FIFO_BASE      = 16'h0240;
   localparam logic [15:0] EP0_BASE       = 16'h0240;
   localparam logic [15:0] EP0_SIZE       = 16'h0040;
   localparam logic [15:0] EP1_BASE       = 16'h0280;
   localparam logic [15:0] EP1_SIZE       = 16'h0080;
   localparam logic [15:0] EP2_BASE       = 16'h0300;
   localparam logic [15:0] EP2_SIZE       = 16'h0140;
   localparam logic [15:0] EP3_BASE       = 16'h0440;
   localparam logic [15:0] EP3_SIZE       = 16'h0200;
   localparam logic [15:0] FIFO_END       = 16'h063F;
   // register indices (printed offset 0x16 is not a multiple of four)
   localparam logic [7:0]  IDX_EP0_CNT    = 8'h16;
   localparam logic [7:0]  IDX_INDEX      = 8'h0E;
   localparam logic [7:0]  IDX_IN_CTRL_HI = 8'h12;
   localparam logic [7:0]  IDX_ENABLE     = 8'h1E;
   localparam logic [7:0]  IDX_IRQ_STAT   = 8'h30;
   localparam logic [7:0]  IDX_IRQ_MASK   = 8'h31;
   localparam logic [7:0]  IDX_EP0_CTRL   = 8'h32;
   // fields of in_endpoint_ctrl_high
   localparam int unsigned BIT_SPLIT      = 2;
   localparam int unsigned BIT_ENDPOINT_DIRECTION_SELECT     = 5;
   // fields of irq registers
   localparam int unsigned IRQ_EP0_RX     = 0;
   localparam int unsigned IRQ_CFG        = 1;
   localparam int unsigned IRQ_W          = 2;
   // reset values and bus response codes
   localparam logic [2:0]  ENABLE_RST     = 3'h7;
   localparam logic [6:0]  CNT_RST        = 7'h00;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   // one endpoint's fifo windows
   typedef struct packed {
      logic        in_ok;
      logic        out_ok;
      logic [15:0] in_lo;
      logic [15:0] in_hi;
      logic [15:0] out_lo;
      logic [15:0] out_hi;
   } uefa_win_s;
endpackage : uefa_pkg
`default_nettype wire

// [verilog/uefa_top.sv]
// usb endpoint fifo allocation and status, axi4-lite register slave
// Behaviour
// - 1024 bytes of fifo storage are shared by endpoints 0 to 3.
// - endpoints 1-3 regions serve in only, out only, or both split in half.
// - split region gives upper half to in, lower half to out.
// - endpoint 3 split: in 0x0540-0x063F, out 0x0440-0x053F.
// - unsplit region is one fifo, usable in one direction at a time.
// - unsplit direction comes from the direction-select bit of in control high.
// - endpoint 0 count register bits 6:0 hold received byte count.
// - endpoint 0 count is valid only while out packet ready is one.
// - count register bit 7 reads zero; writes have no effect.
// - count register at index 0x16, read-only, zero after reset.
// - divide bit one splits the fifo, both pipes available.
// - divide bit zero gives single direction chosen by direction select.
// - one endpoint's control registers visible at a time via selector.
// - disabled endpoint ignores bus traffic; all enabled after reset.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module uefa_top (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [9:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [9:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        ep0_rx_byte,
   input  wire logic        ep0_rx_done,
   input  wire logic [1:0]  fifo_ep,
   input  wire logic        fifo_dir_in,
   input  wire logic [15:0] fifo_addr,
   output logic             fifo_access_ok,
   output logic [6:0]       ep0_rx_byte_count,
   output logic             out_packet_ready,
   output logic             irq
);
   typedef struct packed {
      logic        aw_got;
      logic [7:0]  aw_idx;
      logic        aw_bad;
      logic        w_got;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [1:0]  index;
      logic [2:0]  split;
      logic [2:0]  dir_in;
      logic [2:0]  enable;
      logic [IRQ_W_M1:0] irq_stat;
      logic [IRQ_W_M1:0] irq_mask;
      logic        irq;
      logic        access_ok;
      logic [6:0]  cnt_q;
      logic        rdy_q;
   } uefa_top_s;
   localparam int unsigned IRQ_W_M1 = uefa_pkg::IRQ_W - 1;

   uefa_top_s   st;
   uefa_top_s   next_st;
   uefa_cfg_if  cfg_bus ();
   logic [6:0]  cnt;
   logic        rdy;
   logic        pkt_ev;
   logic        ep0_service;

   assign cfg_bus.split  = st.split;
   assign cfg_bus.dir_in = st.dir_in;
   assign cfg_bus.enable = st.enable;

   uefa_alloc u_alloc (
      .cfg (cfg_bus)
   );

   uefa_ep0_count u_ep0 (
      .clk              (clk),
      .rst              (rst),
      .rx_byte          (ep0_rx_byte),
      .rx_done          (ep0_rx_done),
      .serviced         (ep0_service),
      .count            (cnt),
      .out_packet_ready (rdy),
      .pkt_event        (pkt_ev)
   );

   logic       aw_take;
   logic       w_take;
   logic       do_write;
   logic [7:0] ar_idx;
   logic [31:0] rd_val;
   logic       rd_bad;
   logic       wr_ep0_svc;
   logic       cfg_change;
   logic       lane0;
   uefa_pkg::uefa_win_s sel_win;

   assign aw_take  = s_axi_awvalid && !st.aw_got && !st.bvalid;
   assign w_take   = s_axi_wvalid && !st.w_got && !st.bvalid;
   assign do_write = (st.aw_got || aw_take) && (st.w_got || w_take);
   assign ar_idx   = {2'h0, s_axi_araddr[9:4]} << 2 | {6'h00, s_axi_araddr[3:2]};

   function automatic logic [7:0] idx_of(input logic [9:0] a);
      idx_of = a[9:2];
   endfunction : idx_of

   always_comb begin
      rd_val = 32'h0000_0000;
      rd_bad = 1'b0;
      case (idx_of(s_axi_araddr))
         // bit 7 always zero, read leaves counter untouched
         uefa_pkg::IDX_EP0_CNT:    rd_val = {25'h0, cnt};
         uefa_pkg::IDX_INDEX:      rd_val = {30'h0, st.index};
         uefa_pkg::IDX_IN_CTRL_HI: begin
            // only the selected endpoint's control byte is visible
            if (st.index != 2'h0) begin
               rd_val[uefa_pkg::BIT_SPLIT]  = st.split[st.index - 2'h1];
               rd_val[uefa_pkg::BIT_ENDPOINT_DIRECTION_SELECT] = st.dir_in[st.index - 2'h1];
            end
         end
         uefa_pkg::IDX_ENABLE:     rd_val = {28'h0, st.enable, 1'b1};
         uefa_pkg::IDX_IRQ_STAT:   rd_val = {30'h0, st.irq_stat};
         uefa_pkg::IDX_IRQ_MASK:   rd_val = {30'h0, st.irq_mask};
         uefa_pkg::IDX_EP0_CTRL:   rd_val = {31'h0, rdy};
         default:                  rd_bad = 1'b1;
      endcase
   end

   always_comb begin
      sel_win = cfg_bus.win[0];
      case (fifo_ep)
         2'h1:    sel_win = cfg_bus.win[0];
         2'h2:    sel_win = cfg_bus.win[1];
         2'h3:    sel_win = cfg_bus.win[2];
         default: sel_win = cfg_bus.win[0];
      endcase
   end

   always_comb begin
      logic [7:0]  widx;
      logic [31:0] wd;
      logic [3:0]  ws;
      logic        ok;
      next_st    = st;
      widx       = st.aw_got ? st.aw_idx : s_axi_awaddr[9:2];
      wd         = st.w_got ? st.wdata : s_axi_wdata;
      ws         = st.w_got ? st.wstrb : s_axi_wstrb;
      lane0      = ws[0];
      wr_ep0_svc = 1'b0;
      cfg_change = 1'b0;
      ok         = 1'b0;
      if (aw_take) begin
         next_st.aw_got = 1'b1;
         next_st.aw_idx = s_axi_awaddr[9:2];
      end
      if (w_take) begin
         next_st.w_got = 1'b1;
         next_st.wdata = s_axi_wdata;
         next_st.wstrb = s_axi_wstrb;
      end
      if (do_write) begin
         next_st.aw_got = 1'b0;
         next_st.w_got  = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = uefa_pkg::RESP_OKAY;
         case (widx)
            uefa_pkg::IDX_EP0_CNT: ;
            uefa_pkg::IDX_INDEX: if (lane0) next_st.index = wd[1:0];
            uefa_pkg::IDX_IN_CTRL_HI: begin
               if (lane0 && st.index != 2'h0) begin
                  next_st.split[st.index - 2'h1]  = wd[uefa_pkg::BIT_SPLIT];
                  next_st.dir_in[st.index - 2'h1] = wd[uefa_pkg::BIT_ENDPOINT_DIRECTION_SELECT];
                  cfg_change = 1'b1;
               end
            end
            uefa_pkg::IDX_ENABLE: begin
               if (lane0) begin
                  next_st.enable = wd[3:1];
                  cfg_change     = 1'b1;
               end
            end
            uefa_pkg::IDX_IRQ_STAT: if (lane0) next_st.irq_stat = st.irq_stat & ~wd[1:0];
            uefa_pkg::IDX_IRQ_MASK: if (lane0) next_st.irq_mask = wd[1:0];
            uefa_pkg::IDX_EP0_CTRL: wr_ep0_svc = lane0 & wd[0];
            default: next_st.bresp = uefa_pkg::RESP_SLVERR;
         endcase
      end
      if (st.bvalid && s_axi_bready) next_st.bvalid = 1'b0;
      if (s_axi_arvalid && !st.rvalid) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = rd_val;
         next_st.rresp  = rd_bad ? uefa_pkg::RESP_SLVERR : uefa_pkg::RESP_OKAY;
      end else if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      // set wins over a same-cycle clear
      if (pkt_ev)     next_st.irq_stat[uefa_pkg::IRQ_EP0_RX] = 1'b1;
      if (cfg_change) next_st.irq_stat[uefa_pkg::IRQ_CFG]    = 1'b1;
      next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
      // fifo address check against the selected endpoint's window
      if (fifo_ep == 2'h0) begin
         ok = fifo_addr >= uefa_pkg::EP0_BASE &&
              fifo_addr <  uefa_pkg::EP0_BASE + uefa_pkg::EP0_SIZE;
      end else if (fifo_dir_in) begin
         ok = sel_win.in_ok && fifo_addr >= sel_win.in_lo && fifo_addr <= sel_win.in_hi;
      end else begin
         ok = sel_win.out_ok && fifo_addr >= sel_win.out_lo && fifo_addr <= sel_win.out_hi;
      end
      next_st.access_ok = ok && fifo_addr <= uefa_pkg::FIFO_END;
      next_st.cnt_q     = cnt;
      next_st.rdy_q     = rdy;
   end

   assign ep0_service = wr_ep0_svc;

   always_ff @(posedge clk) begin
      if (rst) begin
         st        <= '0;
         st.enable <= uefa_pkg::ENABLE_RST;
      end else begin
         st <= next_st;
      end
   end

   assign s_axi_awready     = aw_take;
   assign s_axi_wready      = w_take;
   assign s_axi_bvalid      = st.bvalid;
   assign s_axi_bresp       = st.bresp;
   assign s_axi_arready     = s_axi_arvalid && !st.rvalid;
   assign s_axi_rvalid      = st.rvalid;
   assign s_axi_rdata       = st.rdata;
   assign s_axi_rresp       = st.rresp;
   assign fifo_access_ok    = st.access_ok;
   assign ep0_rx_byte_count = st.cnt_q;
   assign out_packet_ready  = st.rdy_q;
   assign irq               = st.irq;

   chk_ep3_split_in: assert property (@(posedge clk) disable iff (rst)
      (st.split[2] && st.enable[2]) |->
      cfg_bus.win[2].in_lo == 16'h0540 && cfg_bus.win[2].in_hi == 16'h063F)
      else $error("endpoint 3 split in window wrong");
   chk_ep3_split_out: assert property (@(posedge clk) disable iff (rst)
      (st.split[2] && st.enable[2]) |->
      cfg_bus.win[2].out_lo == 16'h0440 && cfg_bus.win[2].out_hi == 16'h053F)
      else $error("endpoint 3 split out window wrong");
   chk_unsplit_one_dir: assert property (@(posedge clk) disable iff (rst)
      !st.split[0] |-> !(cfg_bus.win[0].in_ok && cfg_bus.win[0].out_ok))
      else $error("unsplit endpoint allows both directions");
   chk_dir_follows: assert property (@(posedge clk) disable iff (rst)
      (st.enable[1] && !st.split[1]) |-> cfg_bus.win[1].in_ok == st.dir_in[1])
      else $error("unsplit direction does not follow direction select");
   chk_split_both: assert property (@(posedge clk) disable iff (rst)
      (st.enable[0] && st.split[0]) |-> cfg_bus.win[0].in_ok && cfg_bus.win[0].out_ok)
      else $error("split endpoint lacks a pipe");
   chk_disabled_idle: assert property (@(posedge clk) disable iff (rst)
      !st.enable[2] |-> !cfg_bus.win[2].in_ok && !cfg_bus.win[2].out_ok)
      else $error("disabled endpoint still has a window");
   chk_cnt_bit7: assert property (@(posedge clk) disable iff (rst)
      (st.rvalid && $past(idx_of(s_axi_araddr)) == uefa_pkg::IDX_EP0_CNT && $rose(st.rvalid))
      |-> st.rdata[7] == 1'b0)
      else $error("count register bit 7 not zero");
   chk_cnt_reset: assert property (@(posedge clk)
      $past(rst) |-> st.cnt_q == 7'h00 && st.enable == 3'h7)
      else $error("reset values wrong");
   chk_read_no_side: assert property (@(posedge clk) disable iff (rst)
      (s_axi_arvalid && !do_write && !ep0_rx_byte && !ep0_rx_done) |=> $stable(cnt))
      else $error("read disturbed ep0 count");
   chk_irq_level: assert property (@(posedge clk) disable iff (rst)
      ##1 st.irq == |(st.irq_stat & st.irq_mask))
      else $error("irq does not match status and mask");
endmodule : uefa_top
`default_nettype wire
